/* File: rtl/cpu_register_set.sv */
// cpu register set: general registers, program counter, condition code
// assumes the decoder sequences exceptions and drives one write port per file
`timescale 1ns/1ps
`default_nettype none

// Operation
// - eight identical 32-bit general registers, usable for addresses or data
// - each register splits into independent extended and base 16-bit halves
// - each base half splits into independent high and low bytes
// - access width chosen per register, independent of other registers
// - register seven also serves as the stack pointer
// - 24-bit program counter holds next instruction address
// - fetch address forces program counter bit zero to zero
// - reset exception loads program counter from reset vector
// - reset exception sets interrupt mask; other flag bits not initialised
// - mask set blocks all interrupts except the non-maskable one
// - every exception sequence start sets the interrupt mask
// - bits six and four are plain user storage
// - half carry from bit 3, 11 or 27 by operand size
// - negative flag takes result sign bit
// - flags loadable, readable, and, or, xor modifiable; others may hold
// - negative, zero, overflow, carry feed branch conditions
// - zero flag set when the size-selected result part is zero (bits 15:8 for high, 31:16 for extended), cleared otherwise
// - overflow flag follows arithmetic overflow
// - carry flag takes carry, borrow or shift bit; bit accumulator
module cpu_register_set
#(
	parameter int NREG = cpu_regs_pkg::GEN_COUNT
)
(
	input  wire logic                     ref_clk,
	input  wire logic                     rst_b,
	input  wire logic                     clk_en,
	input  wire cpu_regs_pkg::gen_wr_t    gen_wr,
	input  wire logic [2:0]               rd_a_idx,
	input  wire cpu_regs_pkg::part_sel_t  rd_a_sel,
	input  wire logic [2:0]               rd_b_idx,
	input  wire cpu_regs_pkg::part_sel_t  rd_b_sel,
	input  wire logic                     sp_wr_en,
	input  wire logic [31:0]              sp_wr_data,
	input  wire logic                     pc_wr_en,
	input  wire logic [23:0]              pc_wr_data,
	input  wire logic                     reset_vec_load,
	input  wire logic [23:0]              reset_vec_addr,
	input  wire logic                     exc_start,
	input  wire cpu_regs_pkg::cc_op_t     cc_op,
	input  wire logic [7:0]               cc_operand,
	input  wire cpu_regs_pkg::flag_upd_t  flag_upd,
	input  wire logic                     irq_req,
	input  wire logic                     nmi_req,
	output logic [31:0]                   rd_a_data,
	output logic [31:0]                   rd_b_data,
	output logic [31:0]                   stack_ptr,
	output logic [23:0]                   pc_value,
	output logic [23:0]                   fetch_addr,
	output logic [7:0]                    condition_code,
	output cpu_regs_pkg::branch_cond_t    branch_cond,
	output logic                          irq_accept,
	output logic                          nmi_accept
);
	import cpu_regs_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] read_part(input logic [31:0] r, input part_sel_t s);
		logic [31:0] v;
		v = 32'h00000000;
		case (s)
			SEL_EXT:  v = {16'h0000, r[31:16]};
			SEL_BASE: v = {16'h0000, r[15:0]};
			SEL_HIGH: v = {24'h000000, r[15:8]};
			SEL_LOW:  v = {24'h000000, r[7:0]};
			default:  v = r;
		endcase
		return v;
	endfunction

	function automatic logic [31:0] merge_part(input logic [31:0] r, input part_sel_t s,
		input logic [31:0] d);
		logic [31:0] v;
		v = r;
		case (s)
			SEL_EXT:  v = {d[15:0], r[15:0]};
			SEL_BASE: v = {r[31:16], d[15:0]};
			SEL_HIGH: v = {r[31:16], d[7:0], r[7:0]};
			SEL_LOW:  v = {r[31:8], d[7:0]};
			default:  v = d;
		endcase
		return v;
	endfunction

	function automatic logic size_msb(input logic [31:0] x, input part_sel_t s);
		logic b;
		b = x[31];
		case (s)
			SEL_HIGH, SEL_LOW: b = x[7];
			SEL_EXT, SEL_BASE: b = x[15];
			default:           b = x[31];
		endcase
		return b;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// general registers

	logic [31:0] gen_reg [NREG];
	logic [31:0] gen_next [NREG];
	logic [31:0] wr_merged;

	assign wr_merged = merge_part(gen_reg[gen_wr.idx], gen_wr.sel, gen_wr.data);

	always_comb
	begin
		for (int i = 0; i < NREG; i++)
		begin
			gen_next[i] = gen_reg[i];
			if (gen_wr.en && gen_wr.idx == 3'(i))
				gen_next[i] = wr_merged;
		end
		// implicit stack pointer write comes from exception or call sequencing
		if (sp_wr_en)
			gen_next[SP_INDEX] = sp_wr_data;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < NREG; i++)
				gen_reg[i] <= GEN_RESET;
		end
		else if (clk_en)
		begin
			for (int i = 0; i < NREG; i++)
				gen_reg[i] <= gen_next[i];
		end
	end

	logic [31:0] rd_a_next;
	logic [31:0] rd_b_next;

	assign rd_a_next = read_part(gen_next[rd_a_idx], rd_a_sel);
	assign rd_b_next = read_part(gen_next[rd_b_idx], rd_b_sel);

	////////////////////////////////////////////////////////////////////////////
	// program counter

	logic [23:0] pc_reg;
	logic [23:0] pc_next;

	assign pc_next = reset_vec_load ? reset_vec_addr : (pc_wr_en ? pc_wr_data : pc_reg);

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			pc_reg <= PC_RESET;
		else if (clk_en)
			pc_reg <= pc_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// condition code

	logic [7:0]  cc_reg;
	logic [7:0]  cc_next;
	logic [7:0]  cc_logic;
	logic [31:0] opb_eff;
	logic        half_carry;
	logic [31:0] half_mask;
	logic [32:0] low_sum;
	int          hpos;

	// half carry recomputed from the operands so the datapath need not export it
	assign opb_eff = flag_upd.sub ? ~flag_upd.opb : flag_upd.opb;
	assign hpos = (flag_upd.size == SEL_HIGH || flag_upd.size == SEL_LOW) ? HALF_BYTE_POS
		: ((flag_upd.size == SEL_EXT || flag_upd.size == SEL_BASE) ? HALF_WORD_POS
		: HALF_LONG_POS);
	// carry into the tested nibble comes from every lower bit, not only the borrow-in
	assign half_mask = 32'hFFFFFFFF >> (31 - hpos);
	assign low_sum = {1'b0, flag_upd.opa & half_mask} + {1'b0, opb_eff & half_mask}
		+ {32'h00000000, flag_upd.sub};
	assign half_carry = low_sum[hpos + 1] ^ flag_upd.sub;

	always_comb
	begin
		cc_logic = cc_reg;
		case (cc_op)
			CC_LOAD: cc_logic = cc_operand;
			CC_AND:  cc_logic = cc_reg & cc_operand;
			CC_OR:   cc_logic = cc_reg | cc_operand;
			CC_XOR:  cc_logic = cc_reg ^ cc_operand;
			CC_ARITH:
			begin
				if (flag_upd.upd_h)
					cc_logic[CC_HALF_BIT] = half_carry;
				if (flag_upd.upd_n)
					cc_logic[CC_NEG_BIT] = size_msb(flag_upd.result, flag_upd.size);
				if (flag_upd.upd_z)
					cc_logic[CC_ZERO_BIT] = (read_part(flag_upd.result, flag_upd.size)
						== 32'h00000000);
				if (flag_upd.upd_v)
					cc_logic[CC_OVF_BIT] = flag_upd.ovf;
				if (flag_upd.upd_c)
					cc_logic[CC_CARRY_BIT] = flag_upd.carry;
			end
			default: cc_logic = cc_reg;
		endcase
		cc_next = cc_logic;
		// exception entry's mask set wins over any flag operation on the mask bit in the same cycle; other bits follow the operation
		if (exc_start || reset_vec_load)
			cc_next[CC_MASK_BIT] = 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			cc_reg <= CC_RESET;
		else if (clk_en)
			cc_reg <= cc_next;
	end

	////////////////////////////////////////////////////////////////////////////
	// registered outputs

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			rd_a_data      <= GEN_RESET;
			rd_b_data      <= GEN_RESET;
			stack_ptr      <= GEN_RESET;
			pc_value       <= PC_RESET;
			fetch_addr     <= PC_RESET;
			condition_code <= CC_RESET;
			branch_cond    <= '0;
			irq_accept     <= 1'b0;
			nmi_accept     <= 1'b0;
		end
		else if (clk_en)
		begin
			rd_a_data      <= rd_a_next;
			rd_b_data      <= rd_b_next;
			stack_ptr      <= gen_next[SP_INDEX];
			pc_value       <= pc_next;
			fetch_addr     <= {pc_next[23:1], 1'b0};
			condition_code <= cc_next;
			branch_cond    <= {cc_next[CC_NEG_BIT], cc_next[CC_ZERO_BIT],
				cc_next[CC_OVF_BIT], cc_next[CC_CARRY_BIT]};
			irq_accept     <= irq_req && !cc_next[CC_MASK_BIT];
			nmi_accept     <= nmi_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	sequence exc_seen;
		clk_en && (exc_start || reset_vec_load);
	endsequence

	AST_MASK_ON_EXC: assert property (@(posedge ref_clk) disable iff (!rst_b)
		exc_seen |=> condition_code[CC_MASK_BIT])
		else $error("mask not set after exception start");
	AST_IRQ_MASKED: assert property (@(posedge ref_clk) disable iff (!rst_b)
		irq_accept |-> !condition_code[CC_MASK_BIT])
		else $error("interrupt accepted while masked");
	AST_NMI_PASS: assert property (@(posedge ref_clk) disable iff (!rst_b)
		clk_en && nmi_req |=> nmi_accept)
		else $error("nmi not accepted");
	AST_FETCH_EVEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
		fetch_addr == {pc_value[23:1], 1'b0})
		else $error("fetch address not word aligned");
	AST_RESET_VEC: assert property (@(posedge ref_clk) disable iff (!rst_b)
		clk_en && reset_vec_load |=> pc_value == $past(reset_vec_addr))
		else $error("pc not loaded from reset vector");
	AST_LOW_BYTE_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_b)
		clk_en && gen_wr.en && gen_wr.sel == SEL_LOW && !(sp_wr_en && gen_wr.idx == 3'h7)
		|=> gen_reg[$past(gen_wr.idx)][31:8] == $past(gen_reg[gen_wr.idx][31:8]))
		else $error("byte write disturbed upper bits");
	AST_SP_MIRROR: assert property (@(posedge ref_clk) disable iff (!rst_b)
		clk_en |=> stack_ptr == gen_reg[SP_INDEX])
		else $error("stack pointer output stale");
	AST_BRANCH_FLAGS: assert property (@(posedge ref_clk) disable iff (!rst_b)
		branch_cond == {condition_code[CC_NEG_BIT], condition_code[CC_ZERO_BIT],
			condition_code[CC_OVF_BIT], condition_code[CC_CARRY_BIT]})
		else $error("branch conditions differ from flags");
	AST_CC_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_b)
		clk_en && cc_op == CC_LOAD && !exc_start && !reset_vec_load
		|=> condition_code == $past(cc_operand))
		else $error("condition code load lost");

	sequence arith_taken;
		clk_en && cc_op == CC_ARITH && !exc_start && !reset_vec_load;
	endsequence

	AST_USER_BITS_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_b)
		arith_taken |=> condition_code[CC_USER_HI] == $past(cc_reg[CC_USER_HI])
			&& condition_code[CC_USER_LO] == $past(cc_reg[CC_USER_LO]))
		else $error("user bits changed by arithmetic flags");
	AST_IRQ_OPEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
		clk_en && irq_req && !cc_next[CC_MASK_BIT] |=> irq_accept)
		else $error("unmasked interrupt not accepted");
	AST_PC_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_b)
		clk_en && pc_wr_en && !reset_vec_load |=> pc_value == $past(pc_wr_data))
		else $error("pc write lost");
	AST_NEG_BYTE: assert property (@(posedge ref_clk) disable iff (!rst_b)
		arith_taken && flag_upd.upd_n
			&& (flag_upd.size == SEL_LOW || flag_upd.size == SEL_HIGH)
		|=> condition_code[CC_NEG_BIT] == $past(flag_upd.result[7]))
		else $error("negative flag not byte sign");
endmodule

`default_nettype wire

/* File: common/cpu_regs_pkg.sv */
// constants and carriers for the cpu register set
// assumes one core clock; the datapath supplies operands and flag results
`default_nettype none
package cpu_regs_pkg;
	localparam int          GEN_COUNT     = 8;
	localparam int          GEN_WIDTH     = 32;
	localparam int          PC_WIDTH      = 24;
	localparam int          SP_INDEX      = 7;
	localparam int          CC_MASK_BIT   = 7;
	localparam int          CC_USER_HI    = 6;
	localparam int          CC_HALF_BIT   = 5;
	localparam int          CC_USER_LO    = 4;
	localparam int          CC_NEG_BIT    = 3;
	localparam int          CC_ZERO_BIT   = 2;
	localparam int          CC_OVF_BIT    = 1;
	localparam int          CC_CARRY_BIT  = 0;
	localparam int          HALF_BYTE_POS = 3;
	localparam int          HALF_WORD_POS = 11;
	localparam int          HALF_LONG_POS = 27;
	localparam logic [7:0]  CC_RESET      = 8'h80;
	localparam logic [23:0] PC_RESET      = 24'h000000;
	localparam logic [31:0] GEN_RESET     = 32'h00000000;

	// access width and portion selector
	typedef enum logic [2:0]
	{
		SEL_LONG  = 3'h0,
		SEL_EXT   = 3'h1,
		SEL_BASE  = 3'h3,
		SEL_HIGH  = 3'h2,
		SEL_LOW   = 3'h6
	} part_sel_t;

	// condition-code operation
	typedef enum logic [2:0]
	{
		CC_HOLD  = 3'h0,
		CC_LOAD  = 3'h1,
		CC_AND   = 3'h3,
		CC_OR    = 3'h2,
		CC_XOR   = 3'h6,
		CC_ARITH = 3'h7
	} cc_op_t;

	typedef struct packed
	{
		logic       en;
		logic [2:0] idx;
		part_sel_t  sel;
		logic [31:0] data;
	} gen_wr_t;

	typedef struct packed
	{
		logic        upd_h;
		logic        upd_n;
		logic        upd_z;
		logic        upd_v;
		logic        upd_c;
		part_sel_t   size;
		logic [31:0] result;
		logic [31:0] opa;
		logic [31:0] opb;
		logic        sub;
		logic        ovf;
		logic        carry;
	} flag_upd_t;

	typedef struct packed
	{
		logic n;
		logic z;
		logic v;
		logic c;
	} branch_cond_t;
endpackage
`default_nettype wire

/* File: verif/alu_partner.sv */
// datapath model that forms add and subtract results with their flag inputs
// assumes the register set takes flag_upd when cc_op selects arithmetic
`timescale 1ns/1ps
`default_nettype none
module alu_partner
(
	input  wire logic [31:0]              op_a,
	input  wire logic [31:0]              op_b,
	input  wire logic                     sub,
	input  wire cpu_regs_pkg::part_sel_t  size,
	output var  cpu_regs_pkg::flag_upd_t  upd
);
	import cpu_regs_pkg::*;
	int          w;
	logic [31:0] m;
	logic [32:0] r;
	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		w = (size == SEL_LONG) ? 32 : (size == SEL_EXT || size == SEL_BASE) ? 16 : 8;
		m = 32'hFFFFFFFF >> (32 - w);
		r = sub ? {1'b0, op_a & m} - {1'b0, op_b & m} : {1'b0, op_a & m} + {1'b0, op_b & m};
		upd = '0;
		{upd.upd_h, upd.upd_n, upd.upd_z, upd.upd_v, upd.upd_c} = 5'h1F;
		upd.size = size;
		upd.result = r[31:0] & m;
		upd.opa = op_a & m;
		upd.opb = op_b & m;
		upd.sub = sub;
		// sign bits of the operand size, not of the full word
		upd.ovf = (op_a[w-1] ~^ (op_b[w-1] ^ sub)) & (r[w-1] ^ op_a[w-1]);
		upd.carry = r[w];
	end
endmodule
`default_nettype wire

/* File: verif/cpu_register_set_tb_top.sv */
// self-checking bench for the cpu register set
// assumes outputs show the new state just after the edge that takes a request
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set_tb_top;
	import cpu_regs_pkg::*;
	typedef struct packed {logic [2:0] i; part_sel_t s; logic [31:0] d; logic [31:0] e;} row_t;
	typedef struct packed {cc_op_t op; logic [7:0] v; logic [7:0] e;} crow_t;
	typedef struct packed {part_sel_t s; logic [31:0] a; logic [31:0] b; logic u; logic [7:0] e;} arow_t;
	logic ref_clk, rst_b, clk_en, sp_wr_en, pc_wr_en, reset_vec_load, exc_start, irq_req, nmi_req;
	logic irq_accept, nmi_accept, psub;
	logic [2:0] rd_a_idx, rd_b_idx;
	part_sel_t rd_a_sel, rd_b_sel, psize;
	logic [31:0] sp_wr_data, rd_a_data, rd_b_data, stack_ptr, pa, pb;
	logic [23:0] pc_wr_data, reset_vec_addr, pc_value, fetch_addr;
	logic [7:0] cc_operand, condition_code;
	gen_wr_t gen_wr;
	cc_op_t cc_op;
	flag_upd_t flag_upd;
	branch_cond_t branch_cond;
	int errors, n_compared, cyc;
	row_t rows [7] = '{'{3'h2, SEL_LONG, 32'h12345678, 32'h12345678},
		'{3'h2, SEL_LOW, 32'h000000AB, 32'h123456AB}, '{3'h2, SEL_HIGH, 32'h000000CD, 32'h1234CDAB},
		'{3'h2, SEL_EXT, 32'h0000BEEF, 32'hBEEFCDAB}, '{3'h2, SEL_BASE, 32'h00000011, 32'hBEEF0011},
		'{3'h3, SEL_LOW, 32'h00000055, 32'h03030355}, '{3'h7, SEL_LONG, 32'h00FFFF00, 32'h00FFFF00}};
	crow_t crows [6] = '{'{CC_LOAD, 8'h5A, 8'h5A}, '{CC_AND, 8'h0F, 8'h0A}, '{CC_OR, 8'h50, 8'h5A},
		'{CC_XOR, 8'hFF, 8'hA5}, '{CC_HOLD, 8'h00, 8'hA5}, '{CC_LOAD, 8'h00, 8'h00}};
	arow_t arows [4] = '{'{SEL_LOW, 32'h08, 32'h08, 1'b0, 8'h20}, '{SEL_LOW, 32'h80, 32'h80, 1'b0, 8'h07},
		'{SEL_BASE, 32'h0800, 32'h0800, 1'b0, 8'h20}, '{SEL_LONG, 32'h0, 32'h1, 1'b1, 8'h29}};
	////////////////////////////////////////////////////////////////////////////
	cpu_register_set i_dut (.ref_clk, .rst_b, .clk_en, .gen_wr, .rd_a_idx, .rd_a_sel, .rd_b_idx,
		.rd_b_sel, .sp_wr_en, .sp_wr_data, .pc_wr_en, .pc_wr_data, .reset_vec_load, .reset_vec_addr,
		.exc_start, .cc_op, .cc_operand, .flag_upd, .irq_req, .nmi_req, .rd_a_data, .rd_b_data,
		.stack_ptr, .pc_value, .fetch_addr, .condition_code, .branch_cond, .irq_accept, .nmi_accept);
	alu_partner i_alu (.op_a(pa), .op_b(pb), .sub(psub), .size(psize), .upd(flag_upd));
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// a hang shows up as a cycle count far past the hundred or so the run needs
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			errors++;
			end_of_test;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x)
		begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	function automatic logic [31:0] part(input logic [31:0] v, input part_sel_t s);
		case (s)
			SEL_EXT: return {16'h0000, v[31:16]};
			SEL_BASE: return {16'h0000, v[15:0]};
			SEL_HIGH: return {24'h000000, v[15:8]};
			SEL_LOW: return {24'h000000, v[7:0]};
			default: return v;
		endcase
	endfunction
	// strobes drop at the taking edge, so a request is seen once only
	task go;
		@(posedge ref_clk);
		gen_wr.en <= 1'b0;
		sp_wr_en <= 1'b0;
		pc_wr_en <= 1'b0;
		reset_vec_load <= 1'b0;
		exc_start <= 1'b0;
		cc_op <= CC_HOLD;
		#1;
	endtask
	task end_of_test;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{rst_b, sp_wr_en, pc_wr_en, reset_vec_load, exc_start, irq_req, nmi_req, psub} = '0;
		{rd_a_idx, rd_b_idx, sp_wr_data, pc_wr_data, reset_vec_addr, cc_operand, pa, pb} = '0;
		{errors, n_compared, cyc} = '0;
		clk_en = 1'b1;
		gen_wr = '0;
		rd_a_sel = SEL_LONG;
		rd_b_sel = SEL_LONG;
		psize = SEL_LONG;
		cc_op = CC_HOLD;
		repeat (20) @(posedge ref_clk);
		rst_b <= 1'b1;
		#1;
		chk(32'(condition_code), 32'h80);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge ref_clk);
			gen_wr <= '{1'b1, 3'(i), SEL_LONG, {4{8'(i)}}};
			go;
		end
		for (int i = 0; i < 8; i++)
		begin
			@(posedge ref_clk);
			rd_a_idx <= 3'(i);
			go;
			chk(rd_a_data, {4{8'(i)}});
		end
		foreach (rows[k])
		begin
			@(posedge ref_clk);
			gen_wr <= '{1'b1, rows[k].i, rows[k].s, rows[k].d};
			rd_a_idx <= rows[k].i;
			rd_b_idx <= rows[k].i;
			rd_b_sel <= rows[k].s;
			go;
			chk(rd_a_data, rows[k].e);
			chk(rd_b_data, part(rows[k].e, rows[k].s));
		end
		chk(stack_ptr, 32'h00FFFF00);
		@(posedge ref_clk);
		gen_wr <= '{1'b1, 3'h7, SEL_LONG, 32'h12345678};
		sp_wr_en <= 1'b1;
		sp_wr_data <= 32'h0000FF00;
		go;
		chk(stack_ptr, 32'h0000FF00);
		chk(rd_a_data, 32'h0000FF00);
		foreach (crows[k])
		begin
			@(posedge ref_clk);
			cc_op <= crows[k].op;
			cc_operand <= crows[k].v;
			go;
			chk(32'(condition_code), 32'(crows[k].e));
		end
		foreach (arows[k])
		begin
			@(posedge ref_clk);
			psize <= arows[k].s;
			pa <= arows[k].a;
			pb <= arows[k].b;
			psub <= arows[k].u;
			cc_op <= CC_ARITH;
			go;
			chk(32'(condition_code), 32'(arows[k].e));
			chk(32'(branch_cond), 32'(arows[k].e[3:0]));
		end
		@(posedge ref_clk);
		{exc_start, irq_req, nmi_req} <= 3'h7;
		go;
		chk(32'(condition_code), 32'hA9);
		chk(32'({irq_accept, nmi_accept}), 32'h1);
		@(posedge ref_clk);
		cc_op <= CC_LOAD;
		cc_operand <= 8'h00;
		go;
		chk(32'({irq_accept, nmi_accept}), 32'h3);
		@(posedge ref_clk);
		{exc_start, irq_req, nmi_req} <= 3'h4;
		cc_op <= CC_LOAD;
		go;
		chk(32'(condition_code), 32'h80);
		@(posedge ref_clk);
		pc_wr_en <= 1'b1;
		pc_wr_data <= 24'h001235;
		go;
		chk(32'(pc_value), 32'h001235);
		chk(32'(fetch_addr), 32'h001234);
		@(posedge ref_clk);
		{pc_wr_en, reset_vec_load, pc_wr_data, reset_vec_addr} <= {2'h3, 24'h000002, 24'h00ABCD};
		cc_op <= CC_AND;
		go;
		chk(32'(pc_value), 32'h00ABCD);
		chk(32'(condition_code), 32'h80);
		// frozen clock enable must swallow a pending load
		@(posedge ref_clk);
		clk_en <= 1'b0;
		pc_wr_en <= 1'b1;
		go;
		chk(32'(pc_value), 32'h00ABCD);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		rst_b <= 1'b0;
		go;
		chk({8'(condition_code), pc_value}, 32'h80000000);
		chk(stack_ptr, 32'h0);
		@(posedge ref_clk);
		rst_b <= 1'b1;
		end_of_test;
	end
endmodule
`default_nettype wire
